// File: pkg/mlb_pkg.sv
// shared constants and types of the loopback and pattern-test controller
package mlb_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] ERRCNT_OFS = 8'h08;
  localparam int unsigned OFS_W     = 8;

  // control register: buttons and jumpers
  typedef struct packed {
    logic carrier_on;       // line drive jumper, carrier forced on
    logic far_dte_en;       // far_loop_dte_enable_jumper
    logic near_dte_en;      // near_loop_dte_enable_jumper
    logic seq_check;        // sequence_checker_button
    logic far_loop;         // far_end_loop_button
    logic near_loop;        // near_end_line_loop_button
    logic bit_loop;         // local_bitstream_loop_button
  } mlb_ctrl_t;
  localparam int unsigned CTRL_W   = 7;
  localparam mlb_ctrl_t   CTRL_RST = '0;

  // status register layout
  typedef struct packed {
    logic fault_lamp;
    logic err_sticky;
    logic carrier_det;
    logic test_run;
    logic far_loop;
    logic near_loop;
    logic bit_loop;
    logic any_loop;
  } mlb_status_t;
  localparam int unsigned STATUS_W    = 8;
  localparam int unsigned ST_ERR_BIT  = 6;
  localparam int unsigned ERRCNT_W    = 16;

  // pattern generator
  localparam int unsigned PRBS_W      = 9;
  localparam logic [8:0]  PRBS_SEED   = 9'h1ff;
  localparam logic [3:0]  PRBS_FILL   = 4'h9;

  // lamp timing
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned LAMP_CHECK_MS   = 100;
  localparam int unsigned ERR_STRETCH_MS  = 20;
  localparam int unsigned LAMP_CHECK_CYC  = LAMP_CHECK_MS * (CLK_HZ / 1000);
  localparam int unsigned ERR_STRETCH_CYC = ERR_STRETCH_MS * (CLK_HZ / 1000);
  localparam int unsigned TMR_W           = 24;
endpackage

// File: design/mlb_top.sv
// loopback selection, pattern tester and lamp drive with an AHB-Lite slave
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps

// Notes on behaviour
// - bitstream loop echoes optical rx, DSR low
// - near loop feeds transmit into own receiver
// - terminal near-loop request needs its jumper
// - far loop commands peer loop, DSR low
// - terminal far-loop request needs its jumper
// - test sends and checks 511-bit pattern
// - test holds terminal RD and CTS low
// - RTS lamp follows terminal RTS
// - TD lamp on for SPACE, toggles
// - RD lamp on for SPACE, toggles
// - carrier lamp only with valid receive
// - loop lamp lit in any loop mode
// - fault lamp flashes at test start
// - fault lamp steady or blinking on errors
// - checker accepts any source of pattern
// - checker compares whenever pattern loops back; the code makes no compares while the lamp check runs
// - test replaces terminal send data
// - near loop sends steady MARK optically
// - far loop request signals the peer
module mlb_top #(
  parameter int unsigned LAMP_CHECK_CYC  = mlb_pkg::LAMP_CHECK_CYC,
  parameter int unsigned ERR_STRETCH_CYC = mlb_pkg::ERR_STRETCH_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        dte_send_data_in,
  input  wire logic        dte_rts_in,
  input  wire logic        dte_near_req_in,
  input  wire logic        dte_far_req_in,
  input  wire logic        opt_rx_data_in,
  input  wire logic        opt_rx_valid_in,
  input  wire logic        peer_loop_cmd_in,
  output logic             opt_tx_data_out,
  output logic             peer_loop_cmd_out,
  output logic             dte_rx_data_out,
  output logic             dte_cts_out,
  output logic             dte_dsr_out,
  output logic             dte_dcd_out,
  output logic             rts_lamp_out,
  output logic             td_lamp_out,
  output logic             rd_lamp_out,
  output logic             dcd_lamp_out,
  output logic             loop_active_lamp_out,
  output logic             fault_lamp_out
);

  function automatic logic prbs_fb(input logic [8:0] s);
    prbs_fb = s[8] ^ s[4];
  endfunction

  mlb_pkg::mlb_ctrl_t   ctrl_q;
  mlb_pkg::mlb_status_t status;
  logic                 err_sticky_q;
  logic [mlb_pkg::ERRCNT_W-1:0] err_cnt_q;

  // bus address phase capture
  logic                       dp_sel_q;
  logic                       dp_wr_q;
  logic [mlb_pkg::OFS_W-1:0]  dp_addr_q;
  logic                       addr_ok;
  logic                       wr_ctrl;
  logic                       wr_status;
  logic                       wr_cnt;

  // modes and data paths
  logic bit_act;
  logic near_act;
  logic far_act;
  logic sequence_checker_button_act;
  logic carrier_ok;
  logic tx_src;
  logic tx_line;
  logic rx_bit;
  logic rx_valid;

  // pattern tester state
  logic [mlb_pkg::PRBS_W-1:0] gen_q;
  logic [mlb_pkg::PRBS_W-1:0] chk_sr_q;
  logic [3:0]                 fill_q;
  logic                       sequence_checker_button_prev_q;
  logic [mlb_pkg::TMR_W-1:0]  check_tmr_q;
  logic [mlb_pkg::TMR_W-1:0]  stretch_q;
  logic                       bit_err;
  logic                       fault_d;

  assign addr_ok   = hsel_in & htrans_in[1] & hready_in;
  assign wr_ctrl   = dp_sel_q & dp_wr_q & (dp_addr_q == mlb_pkg::CTRL_OFS);
  assign wr_status = dp_sel_q & dp_wr_q & (dp_addr_q == mlb_pkg::STATUS_OFS);
  assign wr_cnt    = dp_sel_q & dp_wr_q & (dp_addr_q == mlb_pkg::ERRCNT_OFS);

  // mode selection from buttons, jumpers and the terminal
  assign bit_act  = ctrl_q.bit_loop | peer_loop_cmd_in;
  assign near_act = ctrl_q.near_loop |
                    (ctrl_q.near_dte_en & dte_near_req_in);
  assign far_act  = ctrl_q.far_loop |
                    (ctrl_q.far_dte_en & dte_far_req_in);
  assign sequence_checker_button_act = ctrl_q.seq_check;

  // without carrier permission the line idles at MARK
  assign carrier_ok = ctrl_q.carrier_on | dte_rts_in;
  assign tx_src  = sequence_checker_button_act ? gen_q[8] : dte_send_data_in;
  assign tx_line = carrier_ok ? tx_src : 1'b1;

  // near loop takes the receive side from our own transmit signal
  assign rx_bit   = near_act ? tx_line : opt_rx_data_in;
  assign rx_valid = near_act ? carrier_ok : opt_rx_valid_in;

  // checker fed from the receive stream, whatever produced the pattern
  assign bit_err = sequence_checker_button_act & rx_valid & (fill_q == mlb_pkg::PRBS_FILL) &
                   (check_tmr_q == '0) &
                   (rx_bit != prbs_fb(chk_sr_q));

  assign fault_d = sequence_checker_button_act & ((check_tmr_q != '0) | (stretch_q != '0));

  always_comb begin
    status             = '0;
    status.any_loop    = bit_act | near_act | far_act;
    status.bit_loop    = bit_act;
    status.near_loop   = near_act;
    status.far_loop    = far_act;
    status.test_run    = sequence_checker_button_act;
    status.carrier_det = rx_valid;
    status.err_sticky  = err_sticky_q;
    status.fault_lamp  = fault_lamp_out;
  end

  // bus slave: zero wait states, OKAY always
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dp_sel_q  <= 1'b0;
      dp_wr_q   <= 1'b0;
      dp_addr_q <= '0;
    end else begin
      dp_sel_q  <= addr_ok;
      dp_wr_q   <= addr_ok & hwrite_in;
      dp_addr_q <= addr_ok ? haddr_in[mlb_pkg::OFS_W-1:0] : dp_addr_q;
    end
  end

  // read data is fetched at the address phase; unmapped reads give zero
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hrdata_out    <= '0;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      hrdata_out    <= '0;
      if (addr_ok && !hwrite_in && haddr_in[31:mlb_pkg::OFS_W] == '0) begin
        unique case (haddr_in[mlb_pkg::OFS_W-1:0])
          mlb_pkg::CTRL_OFS:
            hrdata_out <= {{(32-mlb_pkg::CTRL_W){1'b0}}, ctrl_q};
          mlb_pkg::STATUS_OFS:
            hrdata_out <= {{(32-mlb_pkg::STATUS_W){1'b0}}, status};
          mlb_pkg::ERRCNT_OFS:
            hrdata_out <= {{(32-mlb_pkg::ERRCNT_W){1'b0}}, err_cnt_q};
          default:
            hrdata_out <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q <= mlb_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= mlb_pkg::mlb_ctrl_t'(hwdata_in[mlb_pkg::CTRL_W-1:0]);
    end
  end

  // error flag and count: a new error beats a clear in the same cycle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      err_sticky_q <= 1'b0;
      err_cnt_q    <= '0;
    end else begin
      err_sticky_q <= bit_err |
                      (err_sticky_q & ~(wr_status & hwdata_in[mlb_pkg::ST_ERR_BIT]));
      if (bit_err) begin
        if (wr_cnt) begin
          err_cnt_q <= mlb_pkg::ERRCNT_W'(1);
        end else if (err_cnt_q != '1) begin
          err_cnt_q <= err_cnt_q + mlb_pkg::ERRCNT_W'(1);
        end
      end else if (wr_cnt) begin
        err_cnt_q <= '0;
      end
    end
  end

  // generator: runs only while the test is on and the line may carry it
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gen_q <= mlb_pkg::PRBS_SEED;
    end else if (sequence_checker_button_act && carrier_ok) begin
      gen_q <= {gen_q[7:0], prbs_fb(gen_q)};
    end
  end

  // checker loads received bits, so it locks to any phase of the pattern
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      chk_sr_q <= '0;
      fill_q   <= '0;
    end else if (!sequence_checker_button_act) begin
      fill_q   <= '0;
    end else if (rx_valid) begin
      chk_sr_q <= {chk_sr_q[7:0], rx_bit};
      fill_q   <= (fill_q == mlb_pkg::PRBS_FILL) ? fill_q : fill_q + 4'h1;
    end
  end

  // lamp check at test start, then error stretching
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sequence_checker_button_prev_q <= 1'b0;
      check_tmr_q <= '0;
      stretch_q   <= '0;
    end else begin
      sequence_checker_button_prev_q <= sequence_checker_button_act;
      if (sequence_checker_button_act && !sequence_checker_button_prev_q) begin
        check_tmr_q <= mlb_pkg::TMR_W'(LAMP_CHECK_CYC);
      end else if (check_tmr_q != '0) begin
        check_tmr_q <= check_tmr_q - mlb_pkg::TMR_W'(1);
      end
      // the stretch must end before the next isolated error to blink
      if (!sequence_checker_button_act || check_tmr_q != '0) begin
        stretch_q <= '0;
      end else if (bit_err) begin
        stretch_q <= mlb_pkg::TMR_W'(ERR_STRETCH_CYC);
      end else if (stretch_q != '0) begin
        stretch_q <= stretch_q - mlb_pkg::TMR_W'(1);
      end
    end
  end

  // registered pins and lamps
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      opt_tx_data_out      <= 1'b1;
      peer_loop_cmd_out    <= 1'b0;
      dte_rx_data_out      <= 1'b1;
      dte_cts_out          <= 1'b0;
      dte_dsr_out          <= 1'b1;
      dte_dcd_out          <= 1'b0;
      rts_lamp_out         <= 1'b0;
      td_lamp_out          <= 1'b0;
      rd_lamp_out          <= 1'b0;
      dcd_lamp_out         <= 1'b0;
      loop_active_lamp_out <= 1'b0;
      fault_lamp_out       <= 1'b0;
    end else begin
      if (bit_act) begin
        opt_tx_data_out <= opt_rx_data_in;
      end else if (near_act) begin
        opt_tx_data_out <= 1'b1;
      end else begin
        opt_tx_data_out <= tx_line;
      end
      peer_loop_cmd_out    <= far_act;
      dte_rx_data_out      <= sequence_checker_button_act ? 1'b0 :
                              (rx_valid ? rx_bit : 1'b1);
      dte_cts_out          <= ~sequence_checker_button_act & carrier_ok;
      dte_dsr_out          <= ~(bit_act | far_act);
      dte_dcd_out          <= rx_valid;
      rts_lamp_out         <= dte_rts_in;
      td_lamp_out          <= ~tx_line;
      rd_lamp_out          <= rx_valid & ~rx_bit;
      dcd_lamp_out         <= rx_valid;
      loop_active_lamp_out <= bit_act | near_act | far_act;
      fault_lamp_out       <= fault_d;
    end
  end

  chk_dsr_loop: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (bit_act || far_act) |=> !dte_dsr_out)
    else $error("dsr not low in digital loop");

  chk_bit_echo: assert property (@(posedge clk_in) disable iff (!rstn_in)
    bit_act |=> (opt_tx_data_out == $past(opt_rx_data_in)))
    else $error("bitstream loop does not echo rx");

  chk_near_mark: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (near_act && !bit_act) |=> opt_tx_data_out)
    else $error("near loop not sending mark");

  chk_near_route: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (near_act && carrier_ok && !sequence_checker_button_act) |=>
      (dte_rx_data_out == $past(dte_send_data_in)))
    else $error("near loop does not return transmit data");

  chk_sequence_checker_button_quiet: assert property (@(posedge clk_in) disable iff (!rstn_in)
    sequence_checker_button_act |=> (!dte_rx_data_out && !dte_cts_out))
    else $error("rd or cts active during test");

  chk_peer_cmd: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (ctrl_q.far_dte_en && dte_far_req_in) |=> peer_loop_cmd_out)
    else $error("peer not commanded on far request");

  chk_lamp_check: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ($rose(sequence_checker_button_act) ##1 sequence_checker_button_act [*8]) |=> fault_lamp_out)
    else $error("fault lamp check flash missing");

  chk_err_stretch: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (bit_err ##1 sequence_checker_button_act [*8]) |-> ##1 fault_lamp_out)
    else $error("error not stretched on lamp");

  chk_no_tx_carrier: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (sequence_checker_button_act && !carrier_ok && !bit_act) |=> opt_tx_data_out)
    else $error("pattern sent without carrier");

  chk_loop_lamp: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (bit_act || near_act || far_act) |=> loop_active_lamp_out)
    else $error("loop lamp dark in loop mode");

  chk_rts_lamp: assert property (@(posedge clk_in) disable iff (!rstn_in)
    dte_rts_in |=> rts_lamp_out)
    else $error("rts lamp does not follow rts");

  cov_self_test: cover property (@(posedge clk_in) disable iff (!rstn_in)
    near_act && sequence_checker_button_act && fill_q == mlb_pkg::PRBS_FILL);
  cov_error_seen: cover property (@(posedge clk_in) disable iff (!rstn_in)
    bit_err);
  cov_far_test: cover property (@(posedge clk_in) disable iff (!rstn_in)
    far_act && sequence_checker_button_act);
  cov_peer_loop: cover property (@(posedge clk_in) disable iff (!rstn_in)
    peer_loop_cmd_in ##1 !dte_dsr_out);

endmodule

// File: tb/mlb_partner.sv
// optical line and peer driver model facing the loopback controller
`timescale 1ns/1ps
module mlb_partner (
  input  wire logic clk_in,
  input  wire logic tx_data_in,
  input  wire logic loop_cmd_in,
  input  wire logic echo_en_in,
  input  wire logic valid_en_in,
  input  wire logic err_in,
  input  wire logic own_data_in,
  output logic      rx_data_out,
  output logic      rx_valid_out
);
  initial begin
    rx_data_out  = 1'b1;
    rx_valid_out = 1'b0;
  end

  always @(posedge clk_in) begin
    rx_valid_out <= valid_en_in;
    if (!valid_en_in) begin
      // no light: toggle so a stale level is never mistaken for data
      rx_data_out <= ~rx_data_out;
    end else if (echo_en_in || loop_cmd_in) begin
      rx_data_out <= tx_data_in ^ err_in;
    end else begin
      rx_data_out <= own_data_in;
    end
  end
endmodule

// File: tb/mlb_top_bench.sv
// self-checking bench of the loopback and pattern-test controller
`timescale 1ns/1ps
module mlb_top_bench;
  localparam int unsigned LCHK = 32;
  localparam int unsigned ESTR = 16;
  logic        clk_in, rstn_in, hsel_in, hwrite_in, hready_in;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
  logic [1:0]  htrans_in;
  logic [2:0]  hsize_in;
  logic        hreadyout_out, hresp_out, dte_send_data_in, dte_rts_in;
  logic        dte_near_req_in, dte_far_req_in, opt_rx_data_in;
  logic        opt_rx_valid_in, peer_loop_cmd_in, opt_tx_data_out;
  logic        peer_loop_cmd_out, dte_rx_data_out, dte_cts_out;
  logic        dte_dsr_out, dte_dcd_out, rts_lamp_out, td_lamp_out;
  logic        rd_lamp_out, dcd_lamp_out, loop_active_lamp_out;
  logic        fault_lamp_out, echo_en, valid_en, err, own_data;
  logic [47:0] bits;
  int          error_cnt, cmp_count;

  assign hready_in = hreadyout_out;
  assign hsize_in  = 3'h2;

  mlb_top #(.LAMP_CHECK_CYC(LCHK), .ERR_STRETCH_CYC(ESTR)) dut (
    .clk_in, .rstn_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
    .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out,
    .hresp_out, .dte_send_data_in, .dte_rts_in, .dte_near_req_in,
    .dte_far_req_in, .opt_rx_data_in, .opt_rx_valid_in,
    .peer_loop_cmd_in, .opt_tx_data_out, .peer_loop_cmd_out,
    .dte_rx_data_out, .dte_cts_out, .dte_dsr_out, .dte_dcd_out,
    .rts_lamp_out, .td_lamp_out, .rd_lamp_out, .dcd_lamp_out,
    .loop_active_lamp_out, .fault_lamp_out);

  mlb_partner line (
    .clk_in, .tx_data_in(opt_tx_data_out),
    .loop_cmd_in(peer_loop_cmd_out), .echo_en_in(echo_en),
    .valid_en_in(valid_en), .err_in(err), .own_data_in(own_data),
    .rx_data_out(opt_rx_data_in), .rx_valid_out(opt_rx_valid_in));

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_bit(input string w, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", w, e, g);
    end
  endtask

  task automatic chk_word(input string w, input logic [31:0] e,
                          input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic wait_lvl(ref logic s, input logic v, input int n,
                          input string w);
    for (int i = 0; i < n && s !== v; i++) @(posedge clk_in);
    chk_bit(w, v, s);
    if (s !== v) test_done();
  endtask

  task automatic hold_lvl(ref logic s, input logic v, input int n,
                          input string w);
    repeat (n) begin
      @(posedge clk_in);
      chk_bit(w, v, s);
    end
  endtask

  // waits for the next edge at which hready is sampled high
  task automatic rdy_edge(input string w);
    int i = 0;
    do begin
      @(posedge clk_in);
      i++;
    end while (hreadyout_out !== 1'b1 && i < 50);
    chk_bit(w, 1'b1, hreadyout_out);
    if (hreadyout_out !== 1'b1) test_done();
  endtask

  // one single AHB-Lite transfer; no wait count is assumed
  task automatic bus(input logic wr, input logic [7:0] ofs,
                     input logic [31:0] wd, output logic [31:0] rdv);
    hsel_in   <= 1'b1;
    haddr_in  <= {24'h0, ofs};
    hwrite_in <= wr;
    htrans_in <= 2'h2;
    rdy_edge("hready address");
    htrans_in <= 2'h0;
    hsel_in   <= 1'b0;
    hwdata_in <= wd;
    rdy_edge("hready data");
    rdv = hrdata_out;
    chk_bit("hresp", 1'b0, hresp_out);
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, ofs, v, x);
  endtask

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  initial begin
    rstn_in = 1'b0; hsel_in = 1'b0; haddr_in = '0; htrans_in = '0;
    hwrite_in = 1'b0; hwdata_in = '0; dte_send_data_in = 1'b1;
    dte_rts_in = 1'b0; dte_near_req_in = 1'b0; dte_far_req_in = 1'b0;
    peer_loop_cmd_in = 1'b0; echo_en = 1'b0; valid_en = 1'b0;
    err = 1'b0; own_data = 1'b1;
    tick(5);
    chk_bit("reset tx mark", 1'b1, opt_tx_data_out);
    chk_bit("reset dsr", 1'b1, dte_dsr_out);
    chk_bit("reset fault lamp", 1'b0, fault_lamp_out);
    @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    bus(1'b0, 8'h00, '0, rd); chk_word("ctrl reset", 32'h0, rd);
    bus(1'b0, 8'h04, '0, rd); chk_word("status reset", 32'h0, rd);
    wr(8'hc0, 32'hffff_ffff);
    bus(1'b0, 8'hc0, '0, rd); chk_word("unmapped", 32'h0, rd);
    wr(8'h00, 32'h7f);
    bus(1'b0, 8'h00, '0, rd); chk_word("ctrl rw", 32'h7f, rd);
    wr(8'h00, 32'h0);
    dte_rts_in <= 1'b1; valid_en <= 1'b1; own_data <= 1'b0;
    dte_send_data_in <= 1'b0;
    tick(4);
    chk_bit("rts lamp", 1'b1, rts_lamp_out);
    chk_bit("carrier lamp", 1'b1, dcd_lamp_out);
    chk_bit("dcd pin", 1'b1, dte_dcd_out);
    chk_bit("cts idle", 1'b1, dte_cts_out);
    chk_bit("rd lamp space", 1'b1, rd_lamp_out);
    chk_bit("td lamp space", 1'b1, td_lamp_out);
    dte_rts_in <= 1'b0; valid_en <= 1'b0; dte_send_data_in <= 1'b1;
    tick(4);
    chk_bit("rts lamp off", 1'b0, rts_lamp_out);
    chk_bit("carrier lamp off", 1'b0, dcd_lamp_out);
    chk_bit("dcd pin off", 1'b0, dte_dcd_out);
    chk_bit("td lamp mark", 1'b0, td_lamp_out);
    valid_en <= 1'b1;
    wr(8'h00, 32'h01); tick(4);
    chk_bit("bit loop echo", 1'b0, opt_tx_data_out);
    chk_bit("bit loop dsr", 1'b0, dte_dsr_out);
    chk_bit("bit loop lamp", 1'b1, loop_active_lamp_out);
    dte_send_data_in <= 1'b0;
    // carrier forced on so the looped transmit counts as a valid receive
    wr(8'h00, 32'h42); tick(4);
    chk_bit("near loop mark", 1'b1, opt_tx_data_out);
    chk_bit("near loop rx", 1'b0, dte_rx_data_out);
    chk_bit("near loop lamp", 1'b1, loop_active_lamp_out);
    wr(8'h00, 32'h0); dte_near_req_in <= 1'b1; tick(4);
    chk_bit("near req no jumper", 1'b0, loop_active_lamp_out);
    wr(8'h00, 32'h10); tick(4);
    chk_bit("near req jumper", 1'b1, loop_active_lamp_out);
    dte_near_req_in <= 1'b0;
    wr(8'h00, 32'h04); tick(4);
    chk_bit("far loop cmd", 1'b1, peer_loop_cmd_out);
    chk_bit("far loop dsr", 1'b0, dte_dsr_out);
    wr(8'h00, 32'h0); dte_far_req_in <= 1'b1; tick(4);
    chk_bit("far req no jumper", 1'b0, peer_loop_cmd_out);
    wr(8'h00, 32'h20); tick(4);
    chk_bit("far req jumper", 1'b1, peer_loop_cmd_out);
    dte_far_req_in <= 1'b0; peer_loop_cmd_in <= 1'b1;
    wr(8'h00, 32'h0); tick(4);
    chk_bit("peer loop lamp", 1'b1, loop_active_lamp_out);
    chk_bit("peer loop echo", 1'b0, opt_tx_data_out);
    peer_loop_cmd_in <= 1'b0; echo_en <= 1'b1;
    wr(8'h00, 32'h08);
    hold_lvl(opt_tx_data_out, 1'b1, 20, "test without carrier");
    chk_bit("test rx low", 1'b0, dte_rx_data_out);
    chk_bit("test cts low", 1'b0, dte_cts_out);
    dte_rts_in <= 1'b1;
    wait_lvl(opt_tx_data_out, 1'b0, 20, "test with rts");
    wr(8'h00, 32'h0); dte_rts_in <= 1'b0;
    wr(8'h00, 32'h48);
    wait_lvl(fault_lamp_out, 1'b1, 6, "lamp check on");
    for (int k = 0; k < 48; k++) begin
      @(posedge clk_in);
      bits[k] = opt_tx_data_out;
    end
    for (int k = 9; k < 48; k++)
      chk_bit("pattern bit", bits[k-9] ^ bits[k-5], bits[k]);
    chk_bit("pattern varies", 1'b1, |bits[47:9] & ~&bits[47:9]);
    wait_lvl(fault_lamp_out, 1'b0, LCHK + 20, "lamp check off");
    hold_lvl(fault_lamp_out, 1'b0, 30, "clean loop");
    bus(1'b0, 8'h08, '0, rd); chk_word("no errors", 32'h0, rd);
    err <= 1'b1;
    @(posedge clk_in);
    err <= 1'b0;
    wait_lvl(fault_lamp_out, 1'b1, 12, "single error lamp");
    wait_lvl(fault_lamp_out, 1'b0, ESTR + 30, "blink off");
    bus(1'b0, 8'h08, '0, rd);
    chk_bit("single error count", 1'b1, rd >= 1 && rd <= 3);
    err <= 1'b1;
    wait_lvl(fault_lamp_out, 1'b1, 20, "steady error lamp");
    hold_lvl(fault_lamp_out, 1'b1, 40, "steady error lamp");
    err <= 1'b0;
    wait_lvl(fault_lamp_out, 1'b0, ESTR + 40, "error lamp off");
    bus(1'b0, 8'h04, '0, rd); chk_word("status error", 32'h70, rd);
    wr(8'h04, 32'h40);
    bus(1'b0, 8'h04, '0, rd); chk_word("sticky clear", 32'h30, rd);
    wr(8'h08, 32'h1);
    bus(1'b0, 8'h08, '0, rd); chk_word("count cleared", 32'h0, rd);
    test_done();
  end

  initial begin
    tick(20000);
    error_cnt++;
    $display("mismatch run time expected done seen running");
    test_done();
  end
endmodule
